// ==== shared/jdt_defs.vh ====
// Purpose: Constants for the designated-destination transmit controller
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Offsets 0x0..0x4 are word indexes; byte address is index * 4
`ifndef JDT_DEFS_VH
`define JDT_DEFS_VH
// Control block word indexes
`define JDT_IDX_LEN        3'h0
`define JDT_IDX_RSVA       3'h1
`define JDT_IDX_RESULT     3'h2
`define JDT_IDX_ACTION     3'h3
`define JDT_IDX_RSVB       3'h4
// Extra configuration and status words
`define JDT_IDX_CONFIG     3'h5
`define JDT_IDX_MAXLEN     3'h6
`define JDT_IDX_STATUS     3'h7
// Config field positions
`define JDT_CFG_ENABLE     0
`define JDT_CFG_CYCLE_MODE 1
`define JDT_CFG_TRIGGER    2
`define JDT_CFG_REPLY_OK   3
`define JDT_CFG_CYCLE_OK   4
// Result codes
`define JDT_RES_NORMAL     16'h0000
`define JDT_RES_MULTI_DONE 16'h0001
`define JDT_RES_LEN_ERR    16'h000A
`define JDT_RES_QUEUE_FULL 16'h0014
`define JDT_RES_MULTI_ERR  16'h0064
`define JDT_RES_LOCAL_UNC  16'h00C8
`define JDT_RES_DEST_UNC   16'h00C9
// Sizes and values
`define JDT_MAX_LEN_LIMIT  8'hFC
`define JDT_PACKET_BYTES   8'h08
`define JDT_REQUEST_PGN    18'h0EA00
`define JDT_MAXLEN_RESET   8'h08
`endif

// ==== src/jdt_tx_control.v ====
// Purpose: Transmit control for one destination-specific message
// Assumes: Data storage and CAN engine sit outside, on the same clock
// Notes:   Registers over APB; send runs at an end-of-scan strobe
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "jdt_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Send length-word bytes from storage area
// - Zero length means send configured maximum
// - Length above maximum: no send, code 10
// - Over eight bytes: eight-byte multi-packet transfer
// - Multi-packet completion reports code 1
// - Transmit queue full reports code 20
// - Multi-packet failure reports code 100
// - Own address unconfirmed: refuse, code 200
// - Destination unconfirmed: refuse, code 201
// - Request received sets action bit zero
// - Request bit clears after message sent
// - Event trigger sends at end of scan
// - Trigger bit cleared after event send
// - Answer request only while reply permitted
// - Accepted request sent at next end-of-scan
// - Only enabled messages are transmitted
// - Cycle mode sends each cycle when permitted
// - Copy storage into buffer, then transmit
module jdt_tx_control
(
  // Clock and reset
  input  wire        I_CLK,
  input  wire        I_NRST,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [4:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  // Scan and network state, same clock
  input  wire        I_END_SCAN,
  input  wire        I_CYCLE_TICK,
  input  wire        I_LOCAL_ADDR_OK,
  input  wire        I_DEST_ADDR_OK,
  input  wire        I_REQ_RX,
  input  wire [17:0] I_REQ_PGN,
  // Data storage read port, one-cycle latency
  output reg  [7:0]  O_STORE_ADDR,
  output reg         O_STORE_RD,
  input  wire [7:0]  I_STORE_DATA,
  // Packet handoff to CAN engine
  output reg  [63:0] O_PKT_DATA,
  output reg  [3:0]  O_PKT_LEN,
  output reg         O_PKT_MULTI,
  output reg         O_PKT_VALID,
  input  wire        I_PKT_READY,
  input  wire        I_PKT_FAIL,
  input  wire        I_QUEUE_FULL,
  output reg         O_BUSY
);

////////////////////////////////////////////////////////////////////////////////
// States, one-hot
// ST_DONE lasts one cycle so flags clear before the next start
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_COPY = 5'h02;
localparam [4:0] ST_PACK = 5'h04;
localparam [4:0] ST_SEND = 5'h08;
localparam [4:0] ST_DONE = 5'h10;

// Reset synchroniser
reg         rst_a_reg;        // First stage
reg         rst_b_reg;        // Usable reset
wire        rst_n = rst_b_reg;

// Software-visible state
reg  [15:0] len_reg;          // Transmit length word
reg  [15:0] result_reg;       // Result code
reg         req_seen_reg;     // Request-received flag
reg  [4:0]  cfg_reg;          // Enable, mode, trigger, permits
reg  [7:0]  maxlen_reg;       // Configured maximum length

// Sequencer
reg  [4:0]  state_reg;
reg  [7:0]  total_reg;        // Bytes to send
reg  [7:0]  idx_reg;          // Copy index
reg  [7:0]  sent_reg;         // Bytes handed off
reg         rd_pend_reg;      // Read data due this cycle
// Buffer is not reset; lanes past the message length are masked
reg  [7:0]  buf_mem [0:251];  // Internal transmit buffer
reg         from_req_reg;     // Send serves a request
reg         from_evt_reg;     // Send serves the trigger

// Word index decode, used by read and write paths
function [2:0] reg_index;
  input [4:0] addr;
  begin
    reg_index = addr[4:2];
  end
endfunction

// Writes land on the access edge, where ready is already high
wire        apb_fire = I_PSEL & I_PENABLE;
wire [2:0]  widx     = reg_index(I_PADDR);
wire        wr_len   = apb_fire & I_PWRITE & (widx == `JDT_IDX_LEN);
wire        wr_res   = apb_fire & I_PWRITE & (widx == `JDT_IDX_RESULT);
wire        wr_cfg   = apb_fire & I_PWRITE & (widx == `JDT_IDX_CONFIG);
wire        wr_max   = apb_fire & I_PWRITE & (widx == `JDT_IDX_MAXLEN);

// Request accepted only for our PGN while permitted
wire        req_ok   = I_REQ_RX & (I_REQ_PGN == `JDT_REQUEST_PGN) & cfg_reg[`JDT_CFG_REPLY_OK];

// Send causes, taken only in the end-of-scan phase
wire        enabled  = cfg_reg[`JDT_CFG_ENABLE];
wire        evt_go   = ~cfg_reg[`JDT_CFG_CYCLE_MODE] & cfg_reg[`JDT_CFG_TRIGGER];
wire        cyc_go   = cfg_reg[`JDT_CFG_CYCLE_MODE] & cfg_reg[`JDT_CFG_CYCLE_OK] & I_CYCLE_TICK;
// Trigger and request flags raised while busy wait for a later end of scan; a cycle tick is not held
wire        go       = I_END_SCAN & enabled & (state_reg == ST_IDLE) & (evt_go | cyc_go | req_seen_reg);

// Effective length: zero means the maximum
wire [15:0] eff_len  = (len_reg == 16'h0000) ? {8'h00, maxlen_reg} : len_reg;
wire        len_bad  = eff_len > {8'h00, maxlen_reg};
wire [7:0]  remain   = total_reg - sent_reg;
wire [7:0]  chunk    = (remain > `JDT_PACKET_BYTES) ? `JDT_PACKET_BYTES : remain;
wire        multi    = total_reg > `JDT_PACKET_BYTES;

////////////////////////////////////////////////////////////////////////////////
// Packet byte lanes, byte 0 in the low lane
wire [63:0] pkt_bytes;        // Next packet image
genvar      lane;             // Lane number

generate
  for (lane = 0; lane < 8; lane = lane + 1)
  begin : g_lane
    // Lanes past the chunk read zero, so no stale buffer byte leaks out
    assign pkt_bytes[lane*8 +: 8] = ({24'h000000, chunk} > lane) ? buf_mem[{24'h000000, sent_reg} + lane] : 8'h00;
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Reset release through two flops
// Entry is immediate; exit is timed to the clock so no flop sees a ragged release
always @(posedge I_CLK or negedge I_NRST)
begin
  if (!I_NRST)
  begin
    rst_a_reg <= 1'b0;
    rst_b_reg <= 1'b0;
  end
  else
  begin
    rst_a_reg <= 1'b1;
    rst_b_reg <= rst_a_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////
// APB answer: zero wait states, registered read data
always @(posedge I_CLK or negedge rst_n)
begin
  if (!rst_n)
  begin
    O_PRDATA  <= 32'h00000000;
    O_PREADY  <= 1'b0;
    O_PSLVERR <= 1'b0;
  end
  else
  begin
    // No wait states: every source is a flop here
    O_PREADY  <= I_PSEL & ~I_PENABLE;   // Ready in the access phase
    O_PSLVERR <= 1'b0;                  // Every address answers
    // Read data taken at setup, so it stands through the access edge
    if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
    begin
      case (widx)
        `JDT_IDX_LEN:    O_PRDATA <= {16'h0000, len_reg};
        `JDT_IDX_RESULT: O_PRDATA <= {16'h0000, result_reg};
        `JDT_IDX_ACTION: O_PRDATA <= {31'h00000000, req_seen_reg};
        `JDT_IDX_CONFIG: O_PRDATA <= {27'h0000000, cfg_reg};
        `JDT_IDX_MAXLEN: O_PRDATA <= {24'h000000, maxlen_reg};
        `JDT_IDX_STATUS: O_PRDATA <= {30'h00000000, O_BUSY, multi};
        default:         O_PRDATA <= 32'h00000000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Software registers and flags; hardware set wins over clear
always @(posedge I_CLK or negedge rst_n)
begin
  if (!rst_n)
  begin
    len_reg      <= 16'h0000;
    cfg_reg      <= 5'h00;
    maxlen_reg   <= `JDT_MAXLEN_RESET;
    req_seen_reg <= 1'b0;
  end
  else
  begin
    // Reserved words and the action word have no write path
    if (wr_len)
      len_reg <= I_PWDATA[15:0];
    if (wr_max)
    begin
      // Keep within the 252-byte buffer
      if (I_PWDATA[7:0] > `JDT_MAX_LEN_LIMIT)
        maxlen_reg <= `JDT_MAX_LEN_LIMIT;
      else
        maxlen_reg <= I_PWDATA[7:0];
    end
    // Trigger: set by software, cleared after event send
    if (wr_cfg)
      cfg_reg <= I_PWDATA[4:0];
    else if (state_reg == ST_DONE && from_evt_reg)
      cfg_reg[`JDT_CFG_TRIGGER] <= 1'b0;
    // Request flag: new request beats the clear
    if (req_ok)
      req_seen_reg <= 1'b1;
    else if (state_reg == ST_DONE && from_req_reg)
      req_seen_reg <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Send sequencer: check, copy into buffer, hand off packets
always @(posedge I_CLK or negedge rst_n)
begin
  if (!rst_n)
  begin
    state_reg    <= ST_IDLE;
    result_reg   <= `JDT_RES_NORMAL;
    total_reg    <= 8'h00;
    idx_reg      <= 8'h00;
    sent_reg     <= 8'h00;
    rd_pend_reg  <= 1'b0;
    from_req_reg <= 1'b0;
    from_evt_reg <= 1'b0;
    O_STORE_ADDR <= 8'h00;
    O_STORE_RD   <= 1'b0;
    O_PKT_DATA   <= 64'h0000000000000000;
    O_PKT_LEN    <= 4'h0;
    O_PKT_MULTI  <= 1'b0;
    O_PKT_VALID  <= 1'b0;
    O_BUSY       <= 1'b0;
  end
  else
  begin
    // Software clears the result; a new code in the same cycle wins
    if (wr_res && I_PWDATA[15:0] == 16'h0000)
      result_reg <= `JDT_RES_NORMAL;
    rd_pend_reg <= O_STORE_RD;
    O_STORE_RD  <= 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        // Idle: wait for a cause at the end of scan
        O_BUSY <= 1'b0;
        if (go)
        begin
          // Remember why we started, to clear the right flag at the end
          from_req_reg <= req_seen_reg;
          from_evt_reg <= evt_go;
          // Checks run in fixed order; the first that fails names the result
          if (!I_LOCAL_ADDR_OK)
          begin
            result_reg <= `JDT_RES_LOCAL_UNC;
            state_reg  <= ST_DONE;
          end
          else if (!I_DEST_ADDR_OK)
          begin
            result_reg <= `JDT_RES_DEST_UNC;
            state_reg  <= ST_DONE;
          end
          else if (len_bad)
          begin
            result_reg <= `JDT_RES_LEN_ERR;
            state_reg  <= ST_DONE;
          end
          else if (I_QUEUE_FULL)
          begin
            result_reg <= `JDT_RES_QUEUE_FULL;
            state_reg  <= ST_DONE;
          end
          else if (eff_len == 16'h0000)
          begin
            // Zero maximum leaves nothing to copy; finish rather than stall
            state_reg  <= ST_DONE;
          end
          else
          begin
            total_reg    <= eff_len[7:0];
            idx_reg      <= 8'h00;
            sent_reg     <= 8'h00;
            O_STORE_ADDR <= 8'h00;
            O_STORE_RD   <= 1'b1;
            O_BUSY       <= 1'b1;
            state_reg    <= ST_COPY;
          end
        end
      end
      ST_COPY:
      begin
        // Snapshot storage so later writes cannot tear a message
        // Data stands one cycle after its strobe
        if (rd_pend_reg)
        begin
          buf_mem[idx_reg] <= I_STORE_DATA;
          idx_reg          <= idx_reg + 8'h01;
          if (idx_reg + 8'h01 == total_reg)
            state_reg <= ST_PACK;
        end
        // Next read issued while the last is in flight: one byte a cycle
        if (O_STORE_RD && O_STORE_ADDR + 8'h01 < total_reg)
        begin
          O_STORE_ADDR <= O_STORE_ADDR + 8'h01;
          O_STORE_RD   <= 1'b1;
        end
      end
      ST_PACK:
      begin
        // Build one packet of up to eight bytes from the buffer
        O_PKT_DATA  <= pkt_bytes;
        O_PKT_LEN   <= chunk[3:0];
        O_PKT_MULTI <= multi;
        O_PKT_VALID <= 1'b1;
        state_reg   <= ST_SEND;
      end
      ST_SEND:
      begin
        // Packet holds until the engine answers
        if (I_PKT_FAIL)
        begin
          O_PKT_VALID <= 1'b0;
          // A failed single frame leaves the result as it was
          if (multi)
            result_reg <= `JDT_RES_MULTI_ERR;
          state_reg <= ST_DONE;
        end
        else if (I_PKT_READY)
        begin
          O_PKT_VALID <= 1'b0;
          sent_reg    <= sent_reg + {4'h0, O_PKT_LEN};
          // Last chunk sent: name the result by message size
          if (sent_reg + {4'h0, O_PKT_LEN} >= total_reg)
          begin
            if (multi)
              result_reg <= `JDT_RES_MULTI_DONE;
            else
              result_reg <= `JDT_RES_NORMAL;
            state_reg <= ST_DONE;
          end
          else
            state_reg <= ST_PACK;
        end
      end
      ST_DONE:
      begin
        // One cycle here lets the trigger and request flag clear
        O_BUSY    <= 1'b0;
        state_reg <= ST_IDLE;
      end
      // Stray code: fall back to idle
      default:
        state_reg <= ST_IDLE;
    endcase
  end
end

endmodule // jdt_tx_control

// ==== tb/jdt_assertions.sv ====
// Purpose: Port checks for the transmit controller
// Assumes: One clock, async active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module jdt_assertions
(
  // Clock and reset
  input wire        I_CLK,
  input wire        I_NRST,
  // Watched ports
  input wire        I_END_SCAN,
  input wire        I_LOCAL_ADDR_OK,
  input wire        I_PKT_READY,
  input wire        I_PKT_FAIL,
  input wire        O_PSLVERR,
  input wire [7:0]  O_STORE_ADDR,
  input wire        O_STORE_RD,
  input wire [63:0] O_PKT_DATA,
  input wire [3:0]  O_PKT_LEN,
  input wire        O_PKT_VALID,
  input wire        O_BUSY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_no_slverr: assert property (O_PSLVERR == 1'b0) else $error("slave error raised");
  a_store_step: assert property (O_STORE_RD && $past(O_STORE_RD) |->
    O_STORE_ADDR == $past(O_STORE_ADDR) + 8'h01) else $error("storage address skipped");
  a_copy_first: assert property (O_STORE_RD |-> O_BUSY && !O_PKT_VALID) else $error("copy overlaps send");
  a_pkt_hold: assert property (O_PKT_VALID && !I_PKT_READY && !I_PKT_FAIL |=>
    O_PKT_VALID && $stable(O_PKT_DATA) && $stable(O_PKT_LEN)) else $error("packet dropped early");
  a_pkt_len: assert property (O_PKT_VALID |-> O_PKT_LEN inside {[4'h1:4'h8]}) else $error("bad packet length");
  a_start_scan: assert property ($rose(O_BUSY) |-> $past(I_END_SCAN)) else $error("send outside scan end");
  a_local_block: assert property (I_END_SCAN && !O_BUSY && !I_LOCAL_ADDR_OK |=>
    !O_STORE_RD [*3]) else $error("send without local address");
  a_valid_busy: assert property (O_PKT_VALID |-> O_BUSY) else $error("packet while idle");
  a_copy_start: assert property ($rose(O_BUSY) |->
    O_STORE_RD && O_STORE_ADDR == 8'h00) else $error("copy not from first byte");
endmodule // jdt_assertions
bind jdt_tx_control jdt_assertions jdt_assertions_inst (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_END_SCAN(I_END_SCAN), .I_LOCAL_ADDR_OK(I_LOCAL_ADDR_OK), .I_PKT_READY(I_PKT_READY),
  .I_PKT_FAIL(I_PKT_FAIL), .O_PSLVERR(O_PSLVERR), .O_STORE_ADDR(O_STORE_ADDR), .O_STORE_RD(O_STORE_RD),
  .O_PKT_DATA(O_PKT_DATA), .O_PKT_LEN(O_PKT_LEN), .O_PKT_VALID(O_PKT_VALID), .O_BUSY(O_BUSY));

// ==== tb/jdt_can_model.sv ====
// Purpose: CAN engine stand-in taking packets
// Assumes: Packets held until ready or fail
// Notes:   Latency set by i_lat; fail mode aborts
`timescale 1ns/1ps
module jdt_can_model
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_nrst,
  // Packet side
  input  wire [63:0] i_data,
  input  wire [3:0]  i_len,
  input  wire        i_multi,
  input  wire        i_valid,
  input  wire [3:0]  i_lat,
  input  wire        i_fail_en,
  output reg         o_ready,
  output reg         o_fail,
  output reg  [7:0]  o_cnt,
  output reg  [63:0] o_data,
  output reg  [3:0]  o_len,
  output reg         o_multi
);
  reg [3:0] wait_reg; // Cycles spent on current packet
  // Answer each packet once after the latency
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      {o_ready, o_fail, o_cnt, o_data, o_len, o_multi, wait_reg} <= 0;
    end
    else
    begin
      o_ready <= 1'b0;
      o_fail  <= 1'b0;
      if (i_valid && !o_ready && !o_fail)
      begin
        wait_reg <= (wait_reg == i_lat) ? 4'h0 : wait_reg + 4'h1;
        if (wait_reg == i_lat && i_fail_en)
          o_fail <= 1'b1;
        else if (wait_reg == i_lat)
        begin
          o_ready <= 1'b1;
          o_cnt   <= o_cnt + 8'h01;
          {o_data, o_len, o_multi} <= {i_data, i_len, i_multi};
        end
      end
    end
  end
endmodule // jdt_can_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the transmit controller
// Assumes: APB master, storage and CAN engine modelled here
// Notes:   Storage byte value is its address plus 0x30
`timescale 1ns/1ps
`include "jdt_defs.vh"
module tb;
  reg I_CLK = 0, I_NRST = 0, psel = 0, pen = 0, pwr = 0, es = 0, tick = 0, lok = 1, dok = 1, rq = 0, qf = 0;
  reg [4:0] pa = 0; reg [31:0] pw = 0; reg [17:0] pgn = 0; reg [7:0] sd = 0; reg [3:0] lat = 0; reg fen = 0;
  wire [31:0] prd; wire prdy, srd, pv, pm, rdy, fl; wire [7:0] sa, cnt; wire [63:0] pd, ld; wire [3:0] pl, ll;
  wire lm, busy;
  integer n_fail = 0, cmp_count = 0, k; reg [31:0] r; reg [7:0] c0;
  always #10 I_CLK = ~I_CLK;
  // Storage with one-cycle read latency
  always @(posedge I_CLK) if (srd) sd <= sa + 8'h30;
  jdt_tx_control jdt_tx_control_inst (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pw), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(),
    .I_END_SCAN(es), .I_CYCLE_TICK(tick), .I_LOCAL_ADDR_OK(lok), .I_DEST_ADDR_OK(dok), .I_REQ_RX(rq),
    .I_REQ_PGN(pgn), .O_STORE_ADDR(sa), .O_STORE_RD(srd), .I_STORE_DATA(sd), .O_PKT_DATA(pd),
    .O_PKT_LEN(pl), .O_PKT_MULTI(pm), .O_PKT_VALID(pv), .I_PKT_READY(rdy), .I_PKT_FAIL(fl),
    .I_QUEUE_FULL(qf), .O_BUSY(busy));
  // Priority 0..7 is set in the CAN engine; the stand-in needs none
  jdt_can_model jdt_can_model_inst (.i_clk(I_CLK), .i_nrst(I_NRST), .i_data(pd), .i_len(pl), .i_multi(pm),
    .i_valid(pv), .i_lat(lat), .i_fail_en(fen), .o_ready(rdy), .o_fail(fl), .o_cnt(cnt), .o_data(ld),
    .o_len(ll), .o_multi(lm));
  task conclude;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input string nm, input [63:0] s, input [63:0] e);
  begin
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  // One APB transfer, held until pready
  task apb(input w, input [4:0] a, input [31:0] d);
    integer i;
  begin
    psel <= 1; pwr <= w; pa <= a; pw <= d;
    @(posedge I_CLK) pen <= 1;
    i = 0;
    do begin @(posedge I_CLK); i++; end while (prdy !== 1'b1 && i < 50);
    if (i >= 50) begin n_fail++; conclude; end
    r = prd; psel <= 0; pen <= 0;
    @(posedge I_CLK);
  end
  endtask
  task rd(input [4:0] a, input [31:0] e, input string nm);
  begin apb(0, a, 0); chk(nm, r, e); end
  endtask
  // End-of-scan pulse, then wait for idle
  task scan(input cy);
    integer i;
  begin
    c0 = cnt; es <= 1; tick <= cy;
    @(posedge I_CLK) es <= 0;
    tick <= 0;
    repeat (2) @(posedge I_CLK);
    i = 0;
    while (busy !== 1'b0 && i < 300) begin @(posedge I_CLK); i++; end
    if (i >= 300) begin n_fail++; conclude; end
    repeat (2) @(posedge I_CLK);
  end
  endtask
  task t_regs;
  begin
    rd(5'h00, 0, "len"); rd(5'h08, 0, "res"); rd(5'h0C, 0, "act"); rd(5'h18, 8, "maxlen");
    apb(1, 5'h04, 32'hFFFF); rd(5'h04, 0, "rsva");
    apb(1, 5'h10, 32'hFFFF); rd(5'h10, 0, "rsvb");
    apb(1, 5'h0C, 32'hFFFF); rd(5'h0C, 0, "act_ro");
    apb(1, 5'h18, 32'hFF); rd(5'h18, 32'hFC, "clamp");
  end
  endtask
  task t_event;
  begin
    lat <= 3; apb(1, 5'h00, 3); apb(1, 5'h14, 5); scan(0);
    chk("pkts", cnt - c0, 1);
    chk("plen", ll, 3);
    chk("pdat", ld[23:0], 24'h323130);
    chk("pmul", lm, 0);
    rd(5'h14, 1, "trig");
    rd(5'h08, `JDT_RES_NORMAL, "res0");
  end
  endtask
  task t_multi;
  begin
    lat <= 0; apb(1, 5'h18, 12); apb(1, 5'h00, 0); apb(1, 5'h14, 5); scan(0);
    chk("npk", cnt - c0, 2);
    chk("llen", ll, 4);
    chk("ldat", ld[31:0], 32'h3B3A3938);
    chk("lmul", lm, 1);
    rd(5'h1C, 1, "stat");
    apb(1, 5'h08, 5); rd(5'h08, `JDT_RES_MULTI_DONE, "res1");
    apb(1, 5'h08, 0); rd(5'h08, 0, "clr");
    fen <= 1; apb(1, 5'h00, 10); apb(1, 5'h14, 5); scan(0); fen <= 0;
    rd(5'h08, `JDT_RES_MULTI_ERR, "res100");
    apb(1, 5'h08, 0);
  end
  endtask
  task t_refuse;
    reg [15:0] codes [0:3];
  begin
    codes = '{`JDT_RES_LOCAL_UNC, `JDT_RES_DEST_UNC, `JDT_RES_LEN_ERR, `JDT_RES_QUEUE_FULL};
    for (k = 0; k < 4; k++)
    begin
      lok <= (k != 0); dok <= (k != 1); qf <= (k == 3);
      apb(1, 5'h00, (k == 2) ? 13 : 3); apb(1, 5'h14, 5); scan(0);
      chk("nosend", cnt - c0, 0);
      rd(5'h08, codes[k], "code");
      lok <= 1; dok <= 1; qf <= 0; apb(1, 5'h08, 0);
    end
  end
  endtask
  task t_misc;
  begin
    apb(1, 5'h00, 3); apb(1, 5'h14, 4); scan(0); chk("off", cnt - c0, 0);
    apb(1, 5'h14, 19); scan(1); chk("cyc", cnt - c0, 1);
    apb(1, 5'h14, 1); rq <= 1; pgn <= `JDT_REQUEST_PGN;
    @(posedge I_CLK) rq <= 0;
    @(posedge I_CLK); scan(0); chk("noperm", cnt - c0, 0);
    apb(1, 5'h14, 9); rq <= 1;
    @(posedge I_CLK) rq <= 0;
    @(posedge I_CLK); rd(5'h0C, 1, "reqbit");
    scan(0); chk("reply", cnt - c0, 1);
    rd(5'h0C, 0, "reqclr");
  end
  endtask
  // Reset after register writes brings length, result, config, maximum and action words back to reset values
  task t_reset;
  begin
    apb(1, 5'h00, 5); apb(1, 5'h18, 20); apb(1, 5'h14, 9);
    I_NRST <= 0;
    repeat (2) @(posedge I_CLK);
    I_NRST <= 1;
    repeat (4) @(posedge I_CLK);
    rd(5'h00, 0, "len_rst"); rd(5'h08, 0, "res_rst");
    rd(5'h14, 0, "cfg_rst");
    rd(5'h18, `JDT_MAXLEN_RESET, "max_rst");
    rd(5'h0C, 0, "act_rst");
  end
  endtask
  initial
  begin
    repeat (8) @(posedge I_CLK);
    I_NRST <= 1;
    repeat (4) @(posedge I_CLK);
    t_regs; t_event; t_multi; t_refuse; t_misc; t_reset;
    conclude;
  end
endmodule // tb
